// ### msrb_pkg.sv
// package for the multi-slot receive buffer: layout, flags, timing
// assumes a 125 MHz system clock and byte-wide frame input from a decoder
package msrb_pkg;
   localparam int          SUB_BYTES      = 32;   // bytes per sub-buffer
   localparam int          MAX_FRAMES     = 8;    // responses per cycle
   localparam int          MAX_PAYLOAD    = 28;   // payload byte limit
   localparam int          STATUS_POS     = 28;   // first status byte
   localparam int          BUF_BYTES      = 256;  // whole receive buffer
   localparam logic [7:0]  MAX_LEN_BYTE   = 8'h1C; // 28 as a length byte
   // status word field positions
   localparam int          ST_COUNT_LSB   = 0;    // byte count, 5 bits
   localparam int          ST_COMB_BIT    = 8;    // combined error
   localparam int          ST_INTEG_BIT   = 9;    // integrity error
   localparam int          ST_FRAME_BIT   = 10;   // framing/protocol error
   localparam int          ST_COLL_BIT    = 11;   // collision error
   localparam int          ST_LEN_BIT     = 12;   // length error
   // re-arm gap: at least 2 carrier cycles, up to 2 us
   localparam real         CARRIER_MHZ    = 13.56;
   localparam real         CLK_MHZ        = 125.0;
   localparam real         REARM_MIN_CYC  = 2.0;  // carrier cycles
   localparam int          REARM_CLKS     =
      $rtoi((REARM_MIN_CYC * CLK_MHZ / CARRIER_MHZ) + 0.999);
   localparam logic [4:0]  REARM_W        = 5'(REARM_CLKS);
   typedef enum logic { MSRB_212K, MSRB_424K } msrb_rate_t;
endpackage

// ### msrb_top.sv
// multi-slot receive buffer: stores up to eight slot responses per cycle
// assumes a Manchester decoder on this clock hands over bytes with
// start/end strobes, checksum and collision results at frame end
`timescale 1ns/100ps
module msrb_top (
   // clock and reset
   input  wire logic                 clk_sys_in,
   input  wire logic                 reset_n_in,
   // control
   input  wire logic                 multi_frame_receive_in,
   input  wire logic                 transceive_in,
   input  wire logic                 start_cycle_in,
   input  wire logic                 idle_cmd_in,
   input  wire msrb_pkg::msrb_rate_t rate_in,
   // decoded frame stream
   input  wire logic                 frame_start_in,
   input  wire logic                 byte_valid_in,
   input  wire logic [7:0]           byte_data_in,
   input  wire logic                 frame_end_in,
   input  wire logic                 crc_ok_in,
   input  wire logic                 collision_in,
   // host buffer read port
   input  wire logic [7:0]           rd_addr_in,
   output logic      [7:0]           rd_data_out,
   // status
   output logic                      rx_enable_out,
   output logic                      rx_event_out,
   output logic      [3:0]           frames_received_out,
   output logic                      await_send_state_out,
   output logic                      receiving_out,
   output msrb_pkg::msrb_rate_t      rate_out
);

   typedef enum logic [2:0] {
      MSRB_IDLE, MSRB_ARMED, MSRB_RECV, MSRB_STATUS, MSRB_GAP, MSRB_AWAIT
   } msrb_state_t;

   // state registers and their next values
   msrb_state_t state, next_state;
   logic [3:0]  frames, next_frames;     // 0..8 frames stored
   logic [4:0]  count, next_count;       // bytes stored in this frame
   logic [7:0]  len_byte, next_len_byte; // announced length
   logic        oversize, next_oversize; // length byte above limit
   logic [1:0]  st_idx, next_st_idx;     // status byte being written
   logic [4:0]  gap, next_gap;           // re-arm gap counter
   logic        event_q, next_event_q;   // one-cycle receive event
   logic [15:0] status, next_status;     // status word being written
   msrb_pkg::msrb_rate_t rate, next_rate; // latched bit rate

   // buffer storage and its write port
   logic [7:0]  mem [msrb_pkg::BUF_BYTES];
   logic        wr_en;
   logic [7:0]  wr_addr;
   logic [7:0]  wr_data;
   logic [7:0]  rd_q;

   // base of the current sub-buffer
   logic [7:0]  base;
   // frames[3] is only set once the last sub-buffer has been closed
   assign base = {frames[2:0], 5'h00};

   // next-state logic of the capture sequencer
   always_comb begin
      next_state    = state;
      next_frames   = frames;
      next_count    = count;
      next_len_byte = len_byte;
      next_oversize = oversize;
      next_st_idx   = st_idx;
      next_gap      = gap;
      next_event_q  = 1'b0;
      next_status   = status;
      next_rate     = rate;
      wr_en         = 1'b0;
      wr_addr       = 8'h00;
      wr_data       = 8'h00;
      // idle command wins over every state, mid-frame too; a cut frame
      // leaves its sub-buffer without a status word
      if (idle_cmd_in) begin
         next_state = MSRB_IDLE;
      end else begin
         case (state)
            MSRB_IDLE, MSRB_AWAIT: begin
               // needs both enable and the transceive sequencer
               if (start_cycle_in && multi_frame_receive_in
                   && transceive_in) begin
                  next_frames = 4'h0;
                  next_rate   = rate_in;
                  next_state  = MSRB_ARMED;
               end
            end
            MSRB_ARMED: begin
               if (!multi_frame_receive_in || !transceive_in) begin
                  next_state = MSRB_IDLE;
               end else if (frame_start_in) begin
                  next_count    = 5'h00;
                  next_len_byte = 8'h00;
                  next_oversize = 1'b0;
                  next_state    = MSRB_RECV;
               end
            end
            MSRB_RECV: begin
               if (byte_valid_in) begin
                  // first byte is the length byte; once a frame is oversize
                  // its later bytes must not be taken for a new length
                  if (count == 5'h00 && !oversize) begin
                     next_len_byte = byte_data_in;
                     next_oversize = byte_data_in > msrb_pkg::MAX_LEN_BYTE;
                  end
                  // oversize frames store nothing; cap at 28 bytes
                  if (!(count == 5'h00 &&
                        byte_data_in > msrb_pkg::MAX_LEN_BYTE) && !oversize
                      && count < 5'(msrb_pkg::MAX_PAYLOAD)) begin
                     wr_en      = 1'b1;
                     wr_addr    = base + {3'h0, count};
                     wr_data    = byte_data_in;
                     next_count = count + 5'h01;
                  end
               end
               if (frame_end_in) begin
                  next_status = '0;
                  next_status[msrb_pkg::ST_COUNT_LSB +: 5] = count;
                  next_status[msrb_pkg::ST_INTEG_BIT] =
                     !crc_ok_in && !oversize;
                  next_status[msrb_pkg::ST_FRAME_BIT] =
                     !oversize && ({3'h0, count} < len_byte);
                  next_status[msrb_pkg::ST_COLL_BIT] = collision_in;
                  next_status[msrb_pkg::ST_LEN_BIT] = oversize ||
                     ({3'h0, count} < len_byte);
                  next_status[msrb_pkg::ST_COMB_BIT] =
                     next_status[msrb_pkg::ST_INTEG_BIT] ||
                     next_status[msrb_pkg::ST_FRAME_BIT] ||
                     collision_in;
                  next_st_idx = 2'h0;
                  next_state  = MSRB_STATUS;
               end
            end
            MSRB_STATUS: begin
               // four status bytes, upper two always zero
               wr_en   = 1'b1;
               wr_addr = base + 8'(msrb_pkg::STATUS_POS) + {6'h00, st_idx};
               wr_data = (st_idx == 2'h0) ? status[7:0] :
                         (st_idx == 2'h1) ? status[15:8] : 8'h00;
               next_st_idx = st_idx + 2'h1;
               if (st_idx == 2'h3) begin
                  next_frames  = frames + 4'h1;
                  next_event_q = 1'b1;
                  next_gap     = 5'h00;
                  if (frames == 4'(msrb_pkg::MAX_FRAMES - 1)) begin
                     next_state = MSRB_AWAIT;
                  end else begin
                     next_state = MSRB_GAP;
                  end
               end
            end
            MSRB_GAP: begin
               // receiver stays off for the minimum carrier gap
               // minimum only: a slower re-arm stays within the bound
               next_gap = gap + 5'h01;
               if (gap >= msrb_pkg::REARM_W - 5'h01) begin
                  next_state = MSRB_ARMED;
               end
            end
            default: next_state = MSRB_IDLE;
         endcase
      end
   end

   // sequencer registers
   always_ff @(posedge clk_sys_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         state    <= MSRB_IDLE;
         frames   <= 4'h0;
         count    <= 5'h00;
         len_byte <= 8'h00;
         oversize <= 1'b0;
         st_idx   <= 2'h0;
         gap      <= 5'h00;
         event_q  <= 1'b0;
         status   <= 16'h0000;
         rate     <= msrb_pkg::MSRB_212K;
      end else begin
         state    <= next_state;
         frames   <= next_frames;
         count    <= next_count;
         len_byte <= next_len_byte;
         oversize <= next_oversize;
         st_idx   <= next_st_idx;
         gap      <= next_gap;
         event_q  <= next_event_q;
         status   <= next_status;
         rate     <= next_rate;
      end
   end

   // buffer memory has no reset; unwritten bytes stay undefined
   always_ff @(posedge clk_sys_in) begin
      if (wr_en) begin
         mem[wr_addr] <= wr_data;
      end
      rd_q <= mem[rd_addr_in];
   end

   // status outputs, all decoded from registered state
   assign rd_data_out          = rd_q;
   assign rx_enable_out        = (state == MSRB_ARMED) || (state == MSRB_RECV);
   assign rx_event_out         = event_q;
   assign frames_received_out  = frames;
   assign await_send_state_out = (state == MSRB_AWAIT);
   assign receiving_out        = (state != MSRB_IDLE)
                                 && (state != MSRB_AWAIT);
   assign rate_out             = rate;

   // checks
   a_frame_cap: assert property (@(posedge clk_sys_in) disable iff
      (!reset_n_in) frames <= 4'h8)
      else $error("frame count above eight");
   a_event_count: assert property (@(posedge clk_sys_in) disable iff
      (!reset_n_in) event_q |-> frames == $past(frames) + 4'h1)
      else $error("event without frame count step");
   a_eighth_await: assert property (@(posedge clk_sys_in) disable iff
      (!reset_n_in) (event_q && frames == 4'h8 && !$past(idle_cmd_in))
      |-> state == MSRB_AWAIT)
      else $error("no await after eighth frame");
   a_idle_stops: assert property (@(posedge clk_sys_in) disable iff
      (!reset_n_in) idle_cmd_in |=> state == MSRB_IDLE)
      else $error("idle did not stop reception");
   a_start_clear: assert property (@(posedge clk_sys_in) disable iff
      (!reset_n_in) (state == MSRB_IDLE && start_cycle_in && !idle_cmd_in
      && multi_frame_receive_in && transceive_in) |=> frames == 4'h0)
      else $error("frame count not cleared");
   a_no_enable: assert property (@(posedge clk_sys_in) disable iff
      (!reset_n_in) (state == MSRB_IDLE && !multi_frame_receive_in)
      |=> state == MSRB_IDLE)
      else $error("started without enable");
   a_payload_cap: assert property (@(posedge clk_sys_in) disable iff
      (!reset_n_in) (wr_en && state == MSRB_RECV)
      |-> wr_addr[4:0] < 5'h1C)
      else $error("payload beyond 28 bytes");
   a_rearm_gap: assert property (@(posedge clk_sys_in) disable iff
      (!reset_n_in) (state == MSRB_STATUS && next_state == MSRB_GAP)
      |=> !rx_enable_out [*2])
      else $error("receiver re-armed too soon");
   a_comb_or: assert property (@(posedge clk_sys_in) disable iff
      (!reset_n_in) state == MSRB_STATUS |-> status[8] ==
      (status[9] || status[10] || status[11]))
      else $error("combined error mismatch");
   // per-case status checks look one cycle after the frame end edge,
   // where the registered status word has just been formed; an idle
   // command in that cycle keeps the old word, so it is excluded
   // an oversize length byte locks out every payload write of the frame
   a_oversize_nostore: assert property (
      @(posedge clk_sys_in) disable iff (!reset_n_in)
      (state == MSRB_RECV && oversize) |-> !wr_en)
      else $error("payload stored for oversize frame");
   // the byte counter never runs past the payload limit
   a_count_cap: assert property (
      @(posedge clk_sys_in) disable iff (!reset_n_in)
      count <= 5'h1C)
      else $error("byte count beyond payload limit");
   // oversize length byte must leave the length flag
   a_len_oversize: assert property (
      @(posedge clk_sys_in) disable iff (!reset_n_in)
      (state == MSRB_RECV && frame_end_in && !idle_cmd_in && oversize)
      |=> status[msrb_pkg::ST_LEN_BIT])
      else $error("length error missing on oversize frame");
   // fewer bytes than announced: framing and length flags
   a_short_flags: assert property (
      @(posedge clk_sys_in) disable iff (!reset_n_in)
      (state == MSRB_RECV && frame_end_in && !idle_cmd_in && !oversize
      && {3'h0, count} < len_byte)
      |=> status[msrb_pkg::ST_FRAME_BIT] && status[msrb_pkg::ST_LEN_BIT])
      else $error("short frame not flagged");
   // clean frame of the announced length: no error bit at all
   a_good_clean: assert property (
      @(posedge clk_sys_in) disable iff (!reset_n_in)
      (state == MSRB_RECV && frame_end_in && !idle_cmd_in && !oversize
      && crc_ok_in && !collision_in && {3'h0, count} == len_byte)
      |=> status[12:8] == 5'h00)
      else $error("error bit set on clean frame");
   // checksum failure: integrity and combined flags both set
   a_integ_flags: assert property (
      @(posedge clk_sys_in) disable iff (!reset_n_in)
      (state == MSRB_RECV && frame_end_in && !idle_cmd_in && !oversize
      && !crc_ok_in)
      |=> status[msrb_pkg::ST_INTEG_BIT] && status[msrb_pkg::ST_COMB_BIT])
      else $error("checksum failure not flagged");
   // bytes 30 and 31 of the sub-buffer carry nothing
   a_reserved_zero: assert property (
      @(posedge clk_sys_in) disable iff (!reset_n_in)
      (state == MSRB_STATUS && st_idx[1]) |-> wr_data == 8'h00)
      else $error("reserved status byte not zero");
   // status bytes land in the last word of the current sub-buffer
   a_status_place: assert property (
      @(posedge clk_sys_in) disable iff (!reset_n_in)
      state == MSRB_STATUS |-> wr_en && wr_addr[4:2] == 3'h7
      && wr_addr[7:5] == frames[2:0])
      else $error("status byte outside the last word");
   // end of the gap re-arms the receiver on the next edge
   a_rearm_rise: assert property (
      @(posedge clk_sys_in) disable iff (!reset_n_in)
      (state == MSRB_GAP && gap == msrb_pkg::REARM_W - 5'h01
      && !idle_cmd_in) |=> rx_enable_out)
      else $error("receiver not re-armed after gap");
   // bit rate is latched at cycle start and held throughout
   a_rate_hold: assert property (
      @(posedge clk_sys_in) disable iff (!reset_n_in)
      state == MSRB_RECV |=> rate == $past(rate))
      else $error("bit rate changed inside a cycle");
   // the receive event stands for exactly one cycle per stored frame
   a_event_pulse: assert property (
      @(posedge clk_sys_in) disable iff (!reset_n_in)
      event_q |=> !event_q)
      else $error("receive event longer than one cycle");
   c_eight: cover property (@(posedge clk_sys_in) state == MSRB_AWAIT);
   c_oversize: cover property (@(posedge clk_sys_in)
      state == MSRB_STATUS && oversize);
   c_rearm: cover property (@(posedge clk_sys_in)
      state == MSRB_GAP ##1 state == MSRB_ARMED);
   c_short: cover property (@(posedge clk_sys_in)
      state == MSRB_STATUS && status[msrb_pkg::ST_FRAME_BIT]);
   c_idle_stop: cover property (@(posedge clk_sys_in)
      state == MSRB_GAP && idle_cmd_in);
endmodule // msrb_top

// ### msrb_card.sv
// card model: sends one decoded frame per request, byte 0 is the length
// assumes requests arrive only while the receiver is armed
`timescale 1ns/100ps
module msrb_card (
   // clock and request
   input  wire logic       clk_sys_in,
   input  wire logic       send_in,
   input  wire logic       slow_in,
   input  wire logic [7:0] len_in,
   input  wire logic [7:0] n_in,
   input  wire logic [7:0] salt_in,
   // decoded stream toward the receiver
   output logic            frame_start_out,
   output logic            byte_valid_out,
   output logic [7:0]      byte_data_out,
   output logic            frame_end_out
);
   logic go; // request seen at the edge, before the bench drops it
   // idle data toggles every cycle so a stale byte never looks valid
   initial begin
      {frame_start_out, byte_valid_out, frame_end_out} = 3'h0;
      byte_data_out = 8'hA5;
      forever begin
         @(posedge clk_sys_in);
         go = send_in;
         #1 byte_data_out = ~byte_data_out;
         if (go) begin
            frame_start_out = 1'b1;
            for (int i = 0; i < n_in; i++) begin
               @(posedge clk_sys_in);
               #1 frame_start_out = 1'b0;
               byte_valid_out = 1'b1;
               byte_data_out = (i == 0) ? len_in : salt_in + 8'(i);
               // slow card: one idle cycle between bytes
               if (slow_in) begin
                  @(posedge clk_sys_in);
                  #1 byte_valid_out = 1'b0;
               end
            end
            @(posedge clk_sys_in);
            #1 byte_valid_out = 1'b0;
            frame_end_out = 1'b1;
            @(posedge clk_sys_in);
            #1 frame_end_out = 1'b0;
         end
      end
   end
endmodule // msrb_card

// ### multi_slot_receive_buffer_tb.sv
// bench for the multi-slot receive buffer with a card model on the stream
// assumes crc and collision results are held by the bench over each frame
`timescale 1ns/100ps
module multi_slot_receive_buffer_tb;
   logic                 clk_sys_in = 1'b0;
   logic                 reset_n_in = 1'b0;
   logic                 multi, trx, start, idle, crc, coll, send, slow;
   logic [7:0]           len, n, salt, rd_addr, rd_data, bd;
   logic                 fs, bv, fe, rx_en, rx_ev, await_s, recv;
   logic [3:0]           frames;
   msrb_pkg::msrb_rate_t rate, rate_o;
   int                   error_cnt = 0, n_tests = 0, seed = 32'hcd73;
   always #4 clk_sys_in = ~clk_sys_in; // 125 MHz
   msrb_top dut (.clk_sys_in, .reset_n_in, .multi_frame_receive_in(multi),
      .transceive_in(trx), .start_cycle_in(start), .idle_cmd_in(idle),
      .rate_in(rate), .frame_start_in(fs), .byte_valid_in(bv),
      .byte_data_in(bd), .frame_end_in(fe), .crc_ok_in(crc),
      .collision_in(coll), .rd_addr_in(rd_addr), .rd_data_out(rd_data),
      .rx_enable_out(rx_en), .rx_event_out(rx_ev),
      .frames_received_out(frames), .await_send_state_out(await_s),
      .receiving_out(recv), .rate_out(rate_o));
   msrb_card card (.clk_sys_in, .send_in(send), .slow_in(slow),
      .len_in(len), .n_in(n), .salt_in(salt), .frame_start_out(fs),
      .byte_valid_out(bv), .byte_data_out(bd), .frame_end_out(fe));
   task automatic check(string what, logic [7:0] got, logic [7:0] exp);
      n_tests++;
      if (got !== exp) begin
         error_cnt++;
         $display("MISMATCH %s expected %h seen %h", what, exp, got);
      end
   endtask
   task automatic final_report();
      $display("comparisons %0d mismatches %0d", n_tests, error_cnt);
      if (error_cnt == 0 && n_tests > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
   endtask
   // inputs change 1 ns after the rising edge
   task automatic tick(int k = 1);
      repeat (k) @(posedge clk_sys_in);
      #1;
   endtask
   // bounded wait: 0 for receiver armed, 1 for receive event
   task automatic wait_on(int which);
      int k;
      for (k = 0; k < 200; k++) begin
         if ((which ? rx_ev : rx_en) === 1'b1) break;
         tick();
      end
      if (k == 200) begin
         check("wait", 8'(which), 8'hFF);
         final_report();
      end
   endtask
   task automatic rd(int a, output logic [7:0] d);
      rd_addr = 8'(a);
      tick();
      d = rd_data;
   endtask
   // expected status high byte; length error covers oversize and short
   function automatic logic [7:0] exp_hi(int l, int c, bit ok, bit cl);
      bit big, shrt, integ;
      big = l > 28;
      shrt = c < l && !big;
      integ = !ok && !big;
      return {3'h0, big | shrt, cl, shrt, integ, integ | shrt | cl};
   endfunction
   task automatic frame(int s, int l, int c, bit ok, bit cl);
      logic [7:0] d, m;
      int cc;
      cc = c > 28 ? 28 : c;
      m = l > 28 ? 8'h10 : 8'hFF; // oversize: only the length flag is fixed
      wait_on(0);
      {len, n, crc, coll, send} = {8'(l), 8'(c), ok, cl, 1'b1};
      tick();
      send = 1'b0;
      wait_on(1);
      check("frames", 8'(frames), 8'(s + 1));
      check("gap", 8'(rx_en), 8'h00);
      rd(32 * s + 29, d);
      check("status_hi", d & m, exp_hi(l, cc, ok, cl) & m);
      rd(32 * s + 28, d);
      check("count", d, l > 28 ? 8'h00 : 8'(cc));
      rd(32 * s + 30, d);
      check("rsv30", d, 8'h00);
      rd(32 * s + 31, d);
      check("rsv31", d, 8'h00);
      for (int i = 0; i < cc && l <= 28; i++) begin
         rd(32 * s + i, d);
         check("data", d, i == 0 ? len : salt + 8'(i));
      end
   endtask
   task automatic cyc(msrb_pkg::msrb_rate_t rt);
      rate = rt;
      start = 1'b1;
      tick();
      start = 1'b0;
      tick();
      check("frames_clr", 8'(frames), 8'h00);
      check("rate", 8'(rate_o), 8'(rt));
      check("recv", 8'(recv), 8'h01);
   endtask
   initial begin
      logic [31:0] r;
      int l, c;
      bit ok, cl;
      {multi, trx, start, idle, crc, coll, send, slow} = 8'h00;
      {len, n, salt, rd_addr} = 32'h0;
      rate = msrb_pkg::MSRB_212K;
      tick(2);
      check("frames_rst", 8'(frames), 8'h00);
      reset_n_in = 1'b1;
      // enable bit clear: a start request must be refused
      trx = 1'b1;
      start = 1'b1;
      tick();
      start = 1'b0;
      tick();
      check("recv_off", 8'(recv), 8'h00);
      $display("test disabled done");
      multi = 1'b1;
      cyc(msrb_pkg::MSRB_424K);
      // one slot per case: good, crc, oversize, short, collision, limit, one-byte, good
      for (int s = 0; s < 8; s++) begin
         r = $random(seed);
         {salt, slow} = {r[7:0], r[8]};
         {l, ok, cl} = {2 + int'(r[15:9]) % 27, 2'b10};
         c = l;
         if (s == 1) ok = 1'b0;
         if (s == 2) begin
            l = 30;
            c = 30;
         end
         if (s == 3) c = l - 1;
         if (s == 4) cl = 1'b1;
         if (s == 5) begin
            l = 28;
            c = 30;
         end
         if (s == 6) begin
            l = 1;
            c = 1;
         end
         frame(s, l, c, ok, cl);
      end
      tick();
      check("await", 8'(await_s), 8'h01);
      check("armed8", 8'(rx_en), 8'h00);
      check("frames8", 8'(frames), 8'h08);
      $display("test eight slots done");
      cyc(msrb_pkg::MSRB_212K);
      frame(0, 5, 5, 1'b1, 1'b0);
      idle = 1'b1;
      tick();
      idle = 1'b0;
      tick();
      check("idle_recv", 8'(recv), 8'h00);
      check("idle_arm", 8'(rx_en), 8'h00);
      $display("test idle stop done");
      final_report();
   end
endmodule // multi_slot_receive_buffer_tb
